/* pkg/sbc_pkg.sv */
package sbc_pkg;

  // ***********************************************
  // Bus constants
  // ***********************************************
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'hd2;
  localparam logic [2:0] CMD_BYTE_OP = 3'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ***********************************************
  // Configuration bytes
  // ***********************************************
  localparam logic [4:0] FREQ_SEL_IDX = 5'h00;
  localparam logic [4:0] SPREAD_CPU_IDX = 5'h01;
  localparam logic [7:0] FREQ_SEL_RST = 8'h00;
  localparam logic [7:0] SPREAD_CPU_RST = 8'h0f;
  localparam logic [7:0] FREQ_SEL_MASK = 8'h7e;
  localparam logic [7:0] SPREAD_CPU_MASK = 8'h7f;
  localparam int FREQ_SOURCE_BIT = 3;
  localparam int FREERUN_CTL_BIT = 0;
  localparam int SPREAD_LSB = 4;
  localparam int PAIR_EN_LSB = 1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_CMD = 4'h3,
    ST_CMD_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_HOST_ACK = 4'h8
  } sbc_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } sbc_bus_ev_t;

  typedef struct packed {
    logic [4:0] freq_code;
    logic [2:0] spread_select;
    logic cpu_pair_two_enable;
    logic cpu_pair_one_enable;
    logic cpu_pair_zero_enable;
    logic freerun_pair_enable;
  } sbc_clk_ctrl_t;

endpackage

/* logic/sbc_bus_cond.sv */
`timescale 1ns/1ps

// Turns the sampled bus lines into one-cycle start, stop and edge events.
module sbc_bus_cond (
  clk,
  reset,
  clk_en,
  scl_in,
  sda_in,
  bus_ev
);
  input wire logic clk;
  input wire logic reset;
  input wire logic clk_en;
  input wire logic scl_in;
  input wire logic sda_in;
  output sbc_pkg::sbc_bus_ev_t bus_ev;

  typedef struct packed {
    logic scl_p;
    logic sda_p;
    sbc_pkg::sbc_bus_ev_t ev;
  } sbc_cond_st_t;

  sbc_cond_st_t s_q;
  sbc_cond_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.scl_p = scl_in;
    s_d.sda_p = sda_in;
    s_d.ev.start = scl_in & s_q.scl_p & s_q.sda_p & ~sda_in;
    s_d.ev.stop = scl_in & s_q.scl_p & ~s_q.sda_p & sda_in;
    s_d.ev.rise = scl_in & ~s_q.scl_p;
    s_d.ev.fall = ~scl_in & s_q.scl_p;
    s_d.ev.sda = sda_in;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '{scl_p: 1'b1, sda_p: 1'b1, ev: '{sda: 1'b1, default: 1'b0}};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign bus_ev = s_q.ev;

endmodule

/* logic/sbc_smbus_cfg.sv */
`timescale 1ns/1ps

// Overview of operation
// - A transaction opens with a start, a seven-bit address and write bit, all acknowledged.
// - A command byte of form 100xxxxx is acknowledged and its low five bits pick the byte.
// - A byte write takes one acknowledged data byte into the indexed byte, then a stop.
// - A byte read repeats start, acknowledges the read address and shifts out the byte.
// - Byte zero bits 6..4 are select bits 2..0 and bits 2..1 are select bits 4..3, reset 0.
// - Byte zero bit 3 picks strap pins when 0 and software select bits when 1, reset 0.
// - With byte one bit 0 at 1, its reset value, the free-running pair always runs.
// - With byte one bit 0 at 0, the free-running pair stops while the CPU stop input is low.
// - Only the address byte 11010010 with direction in bit 0 is answered.
// - Command bits 7..5 at 100 mean a byte operation; bit 7 at 0, a block operation, is not answered.
module sbc_smbus_cfg #(
  parameter logic [7:0] SLAVE_ADDR = sbc_pkg::SLAVE_ADDR_BYTE
) (
  clk,
  reset,
  clk_en,
  scl_in,
  sda_in,
  sda_out,
  sda_oe,
  strap_freq_code,
  cpu_stop_n,
  clk_ctrl
);
  input wire logic clk;
  input wire logic reset;
  input wire logic clk_en;
  input wire logic scl_in;
  input wire logic sda_in;
  output logic sda_out;
  output logic sda_oe;
  input wire logic [4:0] strap_freq_code;
  input wire logic cpu_stop_n;
  output sbc_pkg::sbc_clk_ctrl_t clk_ctrl;

  if (SLAVE_ADDR[0] != 1'b0) begin : g_addr_check
    $error("Slave address byte must carry a zero direction bit.");
  end

  // ***********************************************
  // Helpers
  // ***********************************************
  function automatic logic [4:0] sw_freq(input logic [7:0] b0);
    sw_freq = {b0[2], b0[1], b0[6], b0[5], b0[4]};
  endfunction

  function automatic logic [7:0] read_byte(input logic [4:0] idx, input logic [7:0] b0,
                                           input logic [7:0] b1);
    read_byte = 8'h00;
    if (idx == sbc_pkg::FREQ_SEL_IDX) begin
      read_byte = b0;
    end else if (idx == sbc_pkg::SPREAD_CPU_IDX) begin
      read_byte = b1;
    end
  endfunction

  typedef struct packed {
    sbc_pkg::sbc_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [4:0] idx;
    logic rd;
    logic oe;
    logic sda_o;
    logic [7:0] b0;
    logic [7:0] b1;
    sbc_pkg::sbc_clk_ctrl_t ctrl;
  } sbc_cfg_st_t;

  sbc_cfg_st_t s_q;
  sbc_cfg_st_t s_d;
  sbc_pkg::sbc_bus_ev_t ev;
  logic [7:0] rd_byte;
  logic byte_done;

  sbc_bus_cond u_cond (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .bus_ev(ev)
  );

  assign rd_byte = read_byte(s_q.idx, s_q.b0, s_q.b1);
  assign byte_done = ev.fall && (s_q.cnt == sbc_pkg::BITS_PER_BYTE);

  // ***********************************************
  // Protocol engine
  // ***********************************************
  always_comb begin
    s_d = s_q;
    if (ev.start) begin
      s_d.st = sbc_pkg::ST_ADDR;
      s_d.cnt = 4'h0;
      s_d.oe = 1'b0;
    end else if (ev.stop) begin
      s_d.st = sbc_pkg::ST_IDLE;
      s_d.oe = 1'b0;
    end else if (ev.rise) begin
      if (s_q.st == sbc_pkg::ST_ADDR || s_q.st == sbc_pkg::ST_CMD ||
          s_q.st == sbc_pkg::ST_WDATA || s_q.st == sbc_pkg::ST_RDATA) begin
        s_d.sh = {s_q.sh[6:0], ev.sda};
        s_d.cnt = s_q.cnt + 4'h1;
      end
      if (s_q.st == sbc_pkg::ST_RDATA) begin
        s_d.sh = s_q.sh;
      end
    end else if (ev.fall) begin
      unique case (s_q.st)
        sbc_pkg::ST_IDLE: begin
          s_d.oe = 1'b0;
        end
        sbc_pkg::ST_ADDR: begin
          if (byte_done) begin
            if (s_q.sh[7:1] == SLAVE_ADDR[7:1]) begin
              s_d.st = sbc_pkg::ST_ADDR_ACK;
              s_d.rd = s_q.sh[0];
              s_d.oe = 1'b1;
            end else begin
              s_d.st = sbc_pkg::ST_IDLE;
            end
          end
        end
        sbc_pkg::ST_ADDR_ACK: begin
          s_d.cnt = 4'h0;
          if (s_q.rd) begin
            s_d.st = sbc_pkg::ST_RDATA;
            s_d.sh = rd_byte;
            s_d.oe = ~rd_byte[7];
          end else begin
            s_d.st = sbc_pkg::ST_CMD;
            s_d.oe = 1'b0;
          end
        end
        sbc_pkg::ST_CMD: begin
          if (byte_done) begin
            if (s_q.sh[7:5] == sbc_pkg::CMD_BYTE_OP) begin
              s_d.st = sbc_pkg::ST_CMD_ACK;
              s_d.idx = s_q.sh[4:0];
              s_d.oe = 1'b1;
            end else begin
              s_d.st = sbc_pkg::ST_IDLE;
            end
          end
        end
        sbc_pkg::ST_CMD_ACK: begin
          s_d.st = sbc_pkg::ST_WDATA;
          s_d.cnt = 4'h0;
          s_d.oe = 1'b0;
        end
        sbc_pkg::ST_WDATA: begin
          if (byte_done) begin
            s_d.st = sbc_pkg::ST_WDATA_ACK;
            s_d.oe = 1'b1;
            if (s_q.idx == sbc_pkg::FREQ_SEL_IDX) begin
              s_d.b0 = s_q.sh & sbc_pkg::FREQ_SEL_MASK;
            end else if (s_q.idx == sbc_pkg::SPREAD_CPU_IDX) begin
              s_d.b1 = s_q.sh & sbc_pkg::SPREAD_CPU_MASK;
            end
          end
        end
        sbc_pkg::ST_WDATA_ACK: begin
          s_d.st = sbc_pkg::ST_IDLE;
          s_d.oe = 1'b0;
        end
        sbc_pkg::ST_RDATA: begin
          if (byte_done) begin
            s_d.st = sbc_pkg::ST_HOST_ACK;
            s_d.oe = 1'b0;
          end else begin
            s_d.sh = {s_q.sh[6:0], 1'b0};
            s_d.oe = ~s_q.sh[6];
          end
        end
        sbc_pkg::ST_HOST_ACK: begin
          s_d.st = sbc_pkg::ST_IDLE;
          s_d.oe = 1'b0;
        end
        default: begin
          s_d.st = sbc_pkg::ST_IDLE;
          s_d.oe = 1'b0;
        end
      endcase
    end
    s_d.ctrl.freq_code = s_q.b0[sbc_pkg::FREQ_SOURCE_BIT] ? sw_freq(s_q.b0) : strap_freq_code;
    s_d.ctrl.spread_select = s_q.b1[sbc_pkg::SPREAD_LSB+:3];
    {s_d.ctrl.cpu_pair_two_enable, s_d.ctrl.cpu_pair_one_enable,
     s_d.ctrl.cpu_pair_zero_enable} = s_q.b1[sbc_pkg::PAIR_EN_LSB+:3];
    s_d.ctrl.freerun_pair_enable = s_q.b1[sbc_pkg::FREERUN_CTL_BIT] | cpu_stop_n;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '{st: sbc_pkg::ST_IDLE, cnt: 4'h0, sh: 8'h00, idx: 5'h00, rd: 1'b0,
               oe: 1'b0, sda_o: 1'b0, b0: sbc_pkg::FREQ_SEL_RST,
               b1: sbc_pkg::SPREAD_CPU_RST,
               ctrl: '{freq_code: 5'h00, spread_select: 3'h0, default: 1'b1}};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign sda_out = s_q.sda_o;
  assign sda_oe = s_q.oe;
  assign clk_ctrl = s_q.ctrl;

  // ***********************************************
  // Checks
  // ***********************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_addr_ack;
    clk_en && byte_done && s_q.st == sbc_pkg::ST_ADDR && s_q.sh[7:1] == SLAVE_ADDR[7:1]
      |=> s_q.oe && s_q.st == sbc_pkg::ST_ADDR_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("Own address not acknowledged.");

  property p_addr_miss;
    clk_en && byte_done && s_q.st == sbc_pkg::ST_ADDR && s_q.sh[7:1] != SLAVE_ADDR[7:1]
      |=> !s_q.oe && s_q.st == sbc_pkg::ST_IDLE;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("Foreign address answered.");

  property p_cmd_ack;
    clk_en && byte_done && s_q.st == sbc_pkg::ST_CMD && s_q.sh[7:5] == 3'h4
      |=> s_q.oe && s_q.idx == $past(s_q.sh[4:0]);
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("Byte command not taken.");

  property p_cmd_block;
    clk_en && byte_done && s_q.st == sbc_pkg::ST_CMD && !s_q.sh[7]
      |=> !s_q.oe && s_q.st == sbc_pkg::ST_IDLE;
  endproperty
  a_cmd_block: assert property (p_cmd_block) else $error("Block command answered.");

  property p_write;
    clk_en && byte_done && s_q.st == sbc_pkg::ST_WDATA && s_q.idx == 5'h00
      |=> s_q.oe && s_q.b0 == ($past(s_q.sh) & 8'h7e);
  endproperty
  a_write: assert property (p_write) else $error("Write byte not stored.");

  property p_read;
    clk_en && ev.fall && s_q.st == sbc_pkg::ST_ADDR_ACK && s_q.rd
      |=> s_q.st == sbc_pkg::ST_RDATA && s_q.oe == !$past(rd_byte[7]);
  endproperty
  a_read: assert property (p_read) else $error("Read byte not presented.");

  property p_sw_freq;
    !reset && clk_en && s_q.b0[3] |=> clk_ctrl.freq_code == $past(sw_freq(s_q.b0));
  endproperty
  a_sw_freq: assert property (p_sw_freq) else $error("Software select not used.");

  property p_strap_freq;
    !reset && clk_en && !s_q.b0[3] |=> clk_ctrl.freq_code == $past(strap_freq_code);
  endproperty
  a_strap_freq: assert property (p_strap_freq) else $error("Strap select not used.");

  property p_freerun;
    clk_en && s_q.b1[0] |=> clk_ctrl.freerun_pair_enable;
  endproperty
  a_freerun: assert property (p_freerun) else $error("Free-run pair stopped.");

  property p_stop_gate;
    clk_en && !s_q.b1[0] && !cpu_stop_n |=> !clk_ctrl.freerun_pair_enable;
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("Free-run pair not gated.");

  property p_spread;
    clk_en |=> clk_ctrl.spread_select == $past(s_q.b1[6:4]);
  endproperty
  a_spread: assert property (p_spread) else $error("Spread select mismatch.");

  property p_pairs;
    clk_en |=> {clk_ctrl.cpu_pair_two_enable, clk_ctrl.cpu_pair_one_enable,
                clk_ctrl.cpu_pair_zero_enable} == $past(s_q.b1[3:1]) && !s_q.b1[7];
  endproperty
  a_pairs: assert property (p_pairs) else $error("Pair enables mismatch.");

  c_write: cover property (s_q.st == sbc_pkg::ST_WDATA_ACK ##1 s_q.st == sbc_pkg::ST_IDLE);
  c_read: cover property (s_q.st == sbc_pkg::ST_HOST_ACK ##1 s_q.st == sbc_pkg::ST_IDLE);
  c_miss: cover property (byte_done && s_q.st == sbc_pkg::ST_ADDR && s_q.sh[7:1] != SLAVE_ADDR[7:1]);

endmodule

/* sim/sbc_host_model.sv */
`timescale 1ns/1ps

// Bus host that drives SCL and pulls SDA low; a released SDA floats high through the pull-up.
module sbc_host_model (
  clk,
  sda_line,
  scl,
  sda_low
);
  input wire logic clk;
  input wire logic sda_line;
  output logic scl = 1'b1;
  output logic sda_low = 1'b0;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic start();
    // Let a pending SCL fall settle before choosing between start and repeated start.
    tick(1);
    if (scl === 1'b0) begin
      tick(2);
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
    end
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask

  task automatic stop();
    tick(3);
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask

  // SDA changes only while SCL is low, held three clocks past the fall.
  task automatic put_bit(input logic b);
    tick(3);
    sda_low <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask

  task automatic get_bit(output logic b);
    tick(3);
    sda_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(2);
    b = sda_line;
    tick(2);
    scl <= 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(ack_n);
  endtask

  task automatic recv_byte(input logic ack_n, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(ack_n);
  endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps

`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin miscompares++; $display("[ERR] %0t %s", $time, msg); end end

module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic sda_line;
  logic [4:0] strap_freq_code = 5'h00;
  logic cpu_stop_n = 1'b1;
  sbc_pkg::sbc_clk_ctrl_t clk_ctrl;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] b0 = 8'h00;
  logic [7:0] b1 = 8'h0f;
  logic ack_n;
  logic [7:0] rd;

  assign sda_line = ~(sda_low | sda_oe);

  initial begin
    forever #12.5 clk = ~clk;
  end

  sbc_host_model sbc_host_model_inst (
    .clk(clk),
    .sda_line(sda_line),
    .scl(scl),
    .sda_low(sda_low)
  );

  sbc_smbus_cfg sbc_smbus_cfg_inst (
    .clk(clk),
    .reset(reset),
    .clk_en(1'b1),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .strap_freq_code(strap_freq_code),
    .cpu_stop_n(cpu_stop_n),
    .clk_ctrl(clk_ctrl)
  );

  // ***********************************************
  // Bus transactions and reference model
  // ***********************************************
  task automatic addr_cmd(input logic [7:0] cmd);
    sbc_host_model_inst.start();
    sbc_host_model_inst.send_byte(8'hd2, ack_n);
    `CHK(ack_n, 1'b0, "address not acked")
    sbc_host_model_inst.send_byte(cmd, ack_n);
    `CHK(ack_n, 1'b0, "command not acked")
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    addr_cmd({3'h4, idx});
    sbc_host_model_inst.send_byte(d, ack_n);
    `CHK(ack_n, 1'b0, "data not acked")
    sbc_host_model_inst.stop();
    if (idx == 5'h00) b0 = d & 8'h7e;
    if (idx == 5'h01) b1 = d & 8'h7f;
  endtask

  task automatic rdb(input logic [4:0] idx);
    addr_cmd({3'h4, idx});
    sbc_host_model_inst.start();
    sbc_host_model_inst.send_byte(8'hd3, ack_n);
    `CHK(ack_n, 1'b0, "read address not acked")
    sbc_host_model_inst.recv_byte(1'b1, rd);
    sbc_host_model_inst.stop();
    `CHK(rd, (idx == 5'h00) ? b0 : (idx == 5'h01) ? b1 : 8'h00, "read data")
  endtask

  task automatic refused(input logic [7:0] adr, input logic [7:0] cmd);
    sbc_host_model_inst.start();
    sbc_host_model_inst.send_byte(adr, ack_n);
    if (adr == 8'hd2) begin
      sbc_host_model_inst.send_byte(cmd, ack_n);
    end
    `CHK(ack_n, 1'b1, "refused byte was acked")
    sbc_host_model_inst.stop();
  endtask

  task automatic chk_ctrl();
    sbc_pkg::sbc_clk_ctrl_t e;
    repeat (3) @(posedge clk);
    e.freq_code = b0[3] ? {b0[2], b0[1], b0[6], b0[5], b0[4]} : strap_freq_code;
    e.spread_select = b1[6:4];
    e.cpu_pair_two_enable = b1[3];
    e.cpu_pair_one_enable = b1[2];
    e.cpu_pair_zero_enable = b1[1];
    e.freerun_pair_enable = b1[0] | cpu_stop_n;
    `CHK(clk_ctrl, e, "clock control outputs")
    `CHK(sda_out, 1'b0, "sda drive level")
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    void'($urandom(38));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    strap_freq_code <= 5'h15;
    repeat (3) @(posedge clk);
    chk_ctrl();
    rdb(5'h00);
    rdb(5'h01);
    for (int i = 0; i < 8; i++) begin
      wr(5'h01, {i[0], i[2:0], 3'($urandom), i[1]});
      cpu_stop_n <= 1'($urandom);
      chk_ctrl();
      cpu_stop_n <= ~cpu_stop_n;
      chk_ctrl();
    end
    for (int i = 0; i < 6; i++) begin
      wr(5'h00, 8'($urandom) | {4'h0, i[0], 3'h0});
      strap_freq_code <= 5'($urandom);
      chk_ctrl();
      rdb(5'h00);
      rdb(5'h01);
    end
    refused(8'hd4, 8'h80);
    refused(8'hd2, 8'h01);
    refused(8'hd2, 8'ha1);
    refused(8'hd2, 8'hc0);
    wr(5'h05, 8'hff);
    rdb(5'h05);
    rdb(5'h00);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    b0 = 8'h00;
    b1 = 8'h0f;
    chk_ctrl();
    rdb(5'h01);
    give_verdict();
  end
endmodule
